// >>> csc_sample_clock_config.sv
// Serially written configuration words and the sample and oversampling clock enables.
// Assumes serial pins are synchronous to clk and the bit clock is well below clk.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - With fraction select and all fraction fields zero the sample clock is clk over divider times 125.
// - Preset fields a 010101, b 100110 with divider 2 give a sample clock of clk over 256.
// - Preset select 1, a 000011, b 110110 with divider 12 give a sample clock of clk over 1458.
// - Other fraction settings divide clk by 125 times M plus S times N.
// - The oversampling clock is clk over the divider code 1 to 63, and over 64 for code zero.
// - High-pass disable at 1 bypasses both filters, at 0 both filters run.
// - Dither control at 0 applies dither to the D/A, at 1 turns it off.
// - The word is loaded sixteen bit clocks after the falling frame sync.
// - A falling edge on the reset pin restores every configuration default.
module csc_sample_clock_config
(
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  reset_pin_n,
   input  wire logic                  serial_bit_clock,
   input  wire logic                  frameSync,
   input  wire logic                  serialDataIn,
   input  wire logic                  serial_address_pin,
   output var  logic                  sampleClockTick,
   output var  logic                  ovsClockTick,
   output var  logic                  highpassEnable,
   output var  logic                  ditherEnable,
   output var  logic                  porTestEnable,
   output csc_pkg::csc_rate_cfg_t     rateCfg,
   output csc_pkg::csc_filt_cfg_t     filtCfg
);

   logic                            bitClkPrev_ff;
   logic                            syncPrev_ff;
   logic                            rstPinPrev_ff;
   logic                            active_ff;
   logic [3:0]                      bitCnt_ff;
   logic [csc_pkg::WORD_BITS-1:0]   shift_ff;
   logic                            isCtrl_ff;
   logic                            load_ff;
   logic [csc_pkg::WORD_BITS-1:0]   word_ff;
   csc_pkg::csc_rate_cfg_t          rate_ff;
   csc_pkg::csc_filt_cfg_t          filt_ff;
   logic [csc_pkg::DIV_W-1:0]       sampleDiv;
   logic [csc_pkg::DIV_W-1:0]       ovsDivisor;
   logic [6:0]                      ovsEff;
   logic [csc_pkg::DIV_W-1:0]       baseDiv;
   logic                            bitClkRise;
   logic                            syncFall;
   logic                            rstPinFall;
   logic                            lastBit;
   logic                            sampleTick;
   logic                            ovsTick;

   assign bitClkRise = serial_bit_clock & ~bitClkPrev_ff;
   assign syncFall   = ~frameSync & syncPrev_ff;
   assign rstPinFall = ~reset_pin_n & rstPinPrev_ff;
   assign lastBit    = active_ff && bitClkRise && (bitCnt_ff == 4'hf);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bitClkPrev_ff <= 1'b0;
         syncPrev_ff   <= 1'b1;
         rstPinPrev_ff <= 1'b1;
      end
      else
      begin
         bitClkPrev_ff <= serial_bit_clock;
         syncPrev_ff   <= frameSync;
         rstPinPrev_ff <= reset_pin_n;
      end
   end

   // Frame tracking: a new falling sync restarts the count even mid-word.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         active_ff <= 1'b0;
         bitCnt_ff <= '0;
      end
      else if (syncFall)
      begin
         active_ff <= 1'b1;
         bitCnt_ff <= '0;
      end
      else if (active_ff && bitClkRise)
      begin
         bitCnt_ff <= bitCnt_ff + 4'h1;
         if (lastBit)
         begin
            active_ff <= 1'b0;
         end
      end
   end

   // Data enters MSB first; the address pin is inverted and held from the first bit.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         shift_ff  <= '0;
         isCtrl_ff <= 1'b0;
      end
      else if (active_ff && bitClkRise)
      begin
         shift_ff <= {shift_ff[csc_pkg::WORD_BITS-2:0], serialDataIn};
         if (bitCnt_ff == 4'h0)
         begin
            isCtrl_ff <= ~serial_address_pin;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         load_ff <= 1'b0;
         word_ff <= '0;
      end
      else
      begin
         load_ff <= lastBit && isCtrl_ff;
         if (lastBit)
         begin
            word_ff <= {shift_ff[csc_pkg::WORD_BITS-2:0], serialDataIn};
         end
      end
   end

   // Reserved bit is stored as written; the host is expected to keep it zero.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rate_ff <= csc_pkg::RATE_RESET;
         filt_ff <= csc_pkg::FILT_RESET;
      end
      else if (rstPinFall)
      begin
         rate_ff <= csc_pkg::RATE_RESET;
         filt_ff <= csc_pkg::FILT_RESET;
      end
      else if (load_ff)
      begin
         case (word_ff[csc_pkg::WORD_BITS-1 -: 2])
            csc_pkg::SEL_SAMPLE_RATE: rate_ff <= csc_pkg::csc_rate_cfg_t'(word_ff);
            csc_pkg::SEL_FILTER_FRAC: filt_ff <= csc_pkg::csc_filt_cfg_t'(word_ff);
            default:                  ;
         endcase
      end
   end

   // Code zero is the longest division rather than a stopped clock.
   assign ovsEff     = (rate_ff.ovsDiv == 6'h00) ? csc_pkg::OVS_ZERO_DIVISOR
                                                 : {1'b0, rate_ff.ovsDiv};
   assign ovsDivisor = csc_pkg::DIV_W'(ovsEff);
   assign baseDiv    = csc_pkg::DIV_W'(ovsEff * csc_pkg::SAMPLE_BASE);

   // Presets are matched exactly so their published ratios hold regardless of the
   // general formula; other settings use field c as N and the select bit as sign.
   always_comb
   begin
      if (rate_ff.fracSel == csc_pkg::PRESET256_SEL && rate_ff.fracA == csc_pkg::PRESET256_A
          && filt_ff.fracB == csc_pkg::PRESET256_B && filt_ff.fracC == 5'h00
          && rate_ff.ovsDiv == csc_pkg::PRESET256_OVS)
      begin
         sampleDiv = csc_pkg::PRESET256_DIV;
      end
      else if (rate_ff.fracSel == csc_pkg::PRESET1458_SEL
               && rate_ff.fracA == csc_pkg::PRESET1458_A
               && filt_ff.fracB == csc_pkg::PRESET1458_B && filt_ff.fracC == 5'h00
               && rate_ff.ovsDiv == csc_pkg::PRESET1458_OVS)
      begin
         sampleDiv = csc_pkg::PRESET1458_DIV;
      end
      else if (rate_ff.fracSel)
      begin
         sampleDiv = baseDiv - csc_pkg::DIV_W'(filt_ff.fracC);
      end
      else
      begin
         sampleDiv = baseDiv + csc_pkg::DIV_W'(filt_ff.fracC);
      end
   end

   csc_tick_div sampleDivider
   (
      .clk     (clk),
      .resetn  (resetn),
      .divisor (sampleDiv),
      .tick    (sampleTick)
   );

   csc_tick_div ovsDivider
   (
      .clk     (clk),
      .resetn  (resetn),
      .divisor (ovsDivisor),
      .tick    (ovsTick)
   );

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sampleClockTick <= 1'b0;
         ovsClockTick    <= 1'b0;
         highpassEnable  <= 1'b1;
         ditherEnable    <= 1'b1;
         porTestEnable   <= 1'b0;
         rateCfg         <= csc_pkg::RATE_RESET;
         filtCfg         <= csc_pkg::FILT_RESET;
      end
      else
      begin
         sampleClockTick <= sampleTick;
         ovsClockTick    <= ovsTick;
         highpassEnable  <= ~filt_ff.hpDisable;
         ditherEnable    <= ~filt_ff.ditherOff;
         porTestEnable   <= filt_ff.porTest;
         rateCfg         <= rate_ff;
         filtCfg         <= filt_ff;
      end
   end

endmodule
`default_nettype wire

// >>> csc_pkg.sv
// Shared constants and types of the codec sample clock configuration block.
// Assumes a single 10 MHz clock that stands for the divided internal clock.
package csc_pkg;

   localparam int unsigned CLK_HZ    = 10000000;
   localparam int unsigned WORD_BITS = 16;
   localparam int unsigned DIV_W     = 13;

   localparam logic [1:0] SEL_SAMPLE_RATE = 2'h2;
   localparam logic [1:0] SEL_FILTER_FRAC = 2'h3;

   localparam logic [DIV_W-1:0] SAMPLE_BASE      = 13'h007d;
   localparam logic [6:0]       OVS_ZERO_DIVISOR = 7'h40;

   localparam logic       PRESET256_SEL    = 1'h0;
   localparam logic [5:0] PRESET256_A      = 6'h15;
   localparam logic [5:0] PRESET256_B      = 6'h26;
   localparam logic [5:0] PRESET256_OVS    = 6'h02;
   localparam logic [DIV_W-1:0] PRESET256_DIV  = 13'h0100;
   localparam logic       PRESET1458_SEL   = 1'h1;
   localparam logic [5:0] PRESET1458_A     = 6'h03;
   localparam logic [5:0] PRESET1458_B     = 6'h36;
   localparam logic [5:0] PRESET1458_OVS   = 6'h0c;
   localparam logic [DIV_W-1:0] PRESET1458_DIV = 13'h05b2;

   typedef struct packed {
      logic [1:0] regSel;
      logic       reserved;
      logic       fracSel;
      logic [5:0] fracA;
      logic [5:0] ovsDiv;
   } csc_rate_cfg_t;

   typedef struct packed {
      logic [1:0] regSel;
      logic       porTest;
      logic       hpDisable;
      logic       ditherOff;
      logic [4:0] fracC;
      logic [5:0] fracB;
   } csc_filt_cfg_t;

   localparam csc_rate_cfg_t RATE_RESET = '{regSel: SEL_SAMPLE_RATE, default: '0};
   localparam csc_filt_cfg_t FILT_RESET = '{regSel: SEL_FILTER_FRAC, default: '0};

endpackage

// >>> csc_tick_div.sv
// Programmable divider giving a one-cycle enable pulse every divisor cycles.
// Assumes the divisor is at least one and may change at any time.
`timescale 1ns/10ps
`default_nettype none
module csc_tick_div
(
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic [csc_pkg::DIV_W-1:0]  divisor,
   output var  logic                       tick
);

   logic [csc_pkg::DIV_W-1:0] count_ff;
   logic                      wrap;

   // A shrunk divisor must not strand the counter above it, so >= is used.
   assign wrap = (count_ff >= divisor - csc_pkg::DIV_W'(1));

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         count_ff <= '0;
         tick     <= 1'b0;
      end
      else
      begin
         count_ff <= wrap ? '0 : count_ff + csc_pkg::DIV_W'(1);
         tick     <= wrap;
      end
   end

endmodule
`default_nettype wire

// >>> csc_sample_clock_config_asserts.sv
// Concurrent checks on the ports of the sample clock configuration block.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module csc_scc_asserts
(
   input wire logic                   clk,
   input wire logic                   resetn,
   input wire logic                   reset_pin_n,
   input wire logic                   sampleClockTick,
   input wire logic                   ovsClockTick,
   input wire logic                   highpassEnable,
   input wire logic                   ditherEnable,
   input wire logic                   porTestEnable,
   input wire csc_pkg::csc_rate_cfg_t rateCfg,
   input wire csc_pkg::csc_filt_cfg_t filtCfg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence pinDropped;
      $fell(reset_pin_n);
   endsequence
   sequence cfgDefaults;
      rateCfg == 16'h8000 && filtCfg == 16'hc000;
   endsequence

   chk_hp_level: assert property (highpassEnable == !filtCfg.hpDisable)
      else $error("highpass enable disagrees with its control bit");
   chk_dither_level: assert property (ditherEnable == !filtCfg.ditherOff)
      else $error("dither enable disagrees with its control bit");
   chk_por_level: assert property (porTestEnable == filtCfg.porTest)
      else $error("por test output disagrees with its control bit");
   chk_rate_sel: assert property (rateCfg.regSel == 2'h2)
      else $error("rate word holds a foreign select code");
   chk_filt_sel: assert property (filtCfg.regSel == 2'h3)
      else $error("filter word holds a foreign select code");
   chk_pin_reset: assert property (pinDropped |-> ##[1:3] cfgDefaults)
      else $error("reset pin did not restore the defaults");
   // A load may wrap a divider at once. Its tick shows one edge after the config
   // outputs change, so only that edge is excused, for either word that feeds it.
   chk_ovs_gap: assert property ((ovsClockTick && rateCfg.ovsDiv == 6'h00)
      |=> (!ovsClockTick || $past(rateCfg) != $past(rateCfg, 2)) [*6])
      else $error("oversampling tick early for code zero");
   chk_sample_gap: assert property (sampleClockTick
      |=> (!sampleClockTick || $past(rateCfg) != $past(rateCfg, 2)
           || $past(filtCfg) != $past(filtCfg, 2)) [*8])
      else $error("sample tick spacing too short");
endmodule
bind csc_sample_clock_config csc_scc_asserts u_chk (.clk(clk), .resetn(resetn),
   .reset_pin_n(reset_pin_n), .sampleClockTick(sampleClockTick), .ovsClockTick(ovsClockTick),
   .highpassEnable(highpassEnable), .ditherEnable(ditherEnable),
   .porTestEnable(porTestEnable), .rateCfg(rateCfg), .filtCfg(filtCfg));
`default_nettype wire

// >>> csc_host_model.sv
// Host serial port model that writes 16-bit control words.
// Assumes it is driven from the bench clock and changes pins at its falling edge.
`timescale 1ns/10ps
`default_nettype none
module csc_host_model
(
   input  wire logic clk,
   output var  logic serial_bit_clock,
   output var  logic frameSync,
   output var  logic serialDataIn,
   output var  logic serial_address_pin
);
   initial
   begin
      serial_bit_clock = 1'b0;
      frameSync = 1'b1;
      serialDataIn = 1'b0;
      serial_address_pin = 1'b1;
   end
   // The bit clock stands still between frames and the data line is not held.
   task automatic send(input logic [15:0] w, input logic adr, input int h);
      int i;
      @(negedge clk);
      frameSync = 1'b0;
      serial_address_pin = adr;
      for (i = 15; i >= 0; i--)
      begin
         serialDataIn = w[i];
         repeat (h) @(negedge clk);
         serial_bit_clock = 1'b1;
         repeat (h) @(negedge clk);
         serial_bit_clock = 1'b0;
      end
      frameSync = 1'b1;
      serial_address_pin = 1'b1;
      serialDataIn = ~serialDataIn;
   endtask
endmodule
`default_nettype wire

// >>> csc_sample_clock_config_tb.sv
// Self-checking bench for the sample clock configuration block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module csc_sample_clock_config_tb;
   logic clk, resetn, reset_pin_n, bitClk, fSync, sData, sAddr;
   logic sTick, oTick, hpEn, dthEn, porEn;
   csc_pkg::csc_rate_cfg_t rateCfg;
   csc_pkg::csc_filt_cfg_t filtCfg;
   int num_errors = 0, n_tests = 0, n, k;
   logic [15:0] r, f;

   csc_host_model host (.clk(clk), .serial_bit_clock(bitClk), .frameSync(fSync),
      .serialDataIn(sData), .serial_address_pin(sAddr));
   csc_sample_clock_config uut (.clk(clk), .resetn(resetn), .reset_pin_n(reset_pin_n),
      .serial_bit_clock(bitClk), .frameSync(fSync), .serialDataIn(sData),
      .serial_address_pin(sAddr), .sampleClockTick(sTick), .ovsClockTick(oTick),
      .highpassEnable(hpEn), .ditherEnable(dthEn), .porTestEnable(porEn),
      .rateCfg(rateCfg), .filtCfg(filtCfg));

   always #50 clk = ~clk;

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmpWord(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmpCount(input string nm, input int e, input int g);
      n_tests++;
      if (g != e)
      begin
         num_errors++;
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   function automatic int ovsOf(input logic [15:0] rw);
      return (rw[5:0] == 6'h00) ? 64 : int'(rw[5:0]);
   endfunction
   function automatic int sampleOf(input logic [15:0] rw, input logic [15:0] fw);
      if (rw[12:0] == 13'h0542 && fw[10:0] == 11'h026)
         return 256;
      if (rw[12:0] == 13'h10cc && fw[10:0] == 11'h036)
         return 1458;
      return rw[12] ? 125 * ovsOf(rw) - int'(fw[10:6]) : 125 * ovsOf(rw) + int'(fw[10:6]);
   endfunction
   // The first pass only aligns to a tick; the last pass gives one full period.
   task automatic measure(input logic ovs, output int p);
      int i;
      for (i = 0; i < 3; i++)
      begin
         p = 0;
         do
         begin
            @(negedge clk);
            p++;
         end while (!(ovs ? oTick : sTick) && p < 9000);
         if (p >= 9000)
         begin
            num_errors++;
            end_of_test;
         end
      end
   endtask
   task automatic checkCfg(input logic [15:0] rw, input logic [15:0] fw);
      cmpWord("rate word", rw, rateCfg);
      cmpWord("filter word", fw, filtCfg);
      cmpWord("levels", {13'h0000, !fw[12], !fw[11], fw[13]}, {13'h0000, hpEn, dthEn, porEn});
   endtask
   task automatic run(input logic [15:0] rw, input logic [15:0] fw);
      host.send(fw, 1'b0, 1 + int'($urandom % 2));
      host.send(rw, 1'b0, 1 + int'($urandom % 2));
      repeat (4) @(negedge clk);
      checkCfg(rw, fw);
      measure(1'b0, n);
      cmpCount("sample period", sampleOf(rw, fw), n);
      measure(1'b1, n);
      cmpCount("ovs period", ovsOf(rw), n);
      $display("test done rate %h filter %h", rw, fw);
   endtask

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      reset_pin_n = 1'b1;
      void'($urandom(32'h3aaf));
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      checkCfg(16'h8000, 16'hc000);
      measure(1'b0, n);
      cmpCount("default sample", 8000, n);
      run(16'h90cc, 16'hc036);
      // Divider codes of five or more keep the host bit clock faster than the
      // oversampling clock; the divide-by-256 preset runs last for the same reason.
      for (k = 0; k < 4; k++)
      begin
         r = {3'h4, 1'($urandom), 6'($urandom), 6'(5 + $urandom % 4)};
         f = {2'h3, 3'($urandom), 5'($urandom), 2'h0, 4'($urandom)};
         run(r, f);
      end
      run(16'h803f, 16'hc000);
      host.send(16'h4001, 1'b0, 1);
      host.send(16'h0001, 1'b0, 2);
      host.send(16'h8001, 1'b1, 1);
      repeat (4) @(negedge clk);
      checkCfg(16'h803f, 16'hc000);
      $display("test refused words done");
      run(16'h8542, 16'hc026);
      reset_pin_n = 1'b0;
      repeat (4) @(negedge clk);
      reset_pin_n = 1'b1;
      checkCfg(16'h8000, 16'hc000);
      $display("test reset pin done");
      end_of_test;
   end
endmodule
`default_nettype wire
